// ===== design/pll_supervisor_consts.vh
// register offsets, field positions and reset values of the pll supervision bank
// included by the pll supervision register bank; definitions only
`ifndef PLL_SUPERVISOR_CONSTS_VH
`define PLL_SUPERVISOR_CONSTS_VH
`define ADDR_LOCK_CAL 10'h018
`define ADDR_ALIGN_RST 10'h019
`define ADDR_LOCK_PIN 10'h01a
`define ADDR_MON_EN 10'h01b
`define ADDR_REF_SEL 10'h01c
`define ADDR_HOLDOVER 10'h01d
`define ADDR_STATUS 10'h01f
`define ADDR_READBACK_SEL 10'h004
`define ADDR_UPDATE 10'h232
`define RST_LOCK_CAL 8'h06
`define RST_ALIGN_RST 8'h00
`define RST_LOCK_PIN 8'h00
`define RST_MON_EN 8'h00
`define RST_REF_SEL 8'h00
`define RST_HOLDOVER 8'h00
`define BIT_LOCK_DIS 3
`define BIT_CAL_NOW 0
`define BIT_REF_THRESH 6
`define BIT_MON_VCO 7
`define BIT_MON_SEC 6
`define BIT_MON_PRI 5
`define BIT_SEL_SEC 6
`define BIT_USE_PIN 5
`define BIT_AUTO_SW 4
`define BIT_STAY_SEC 3
`define BIT_PWR_SEC 2
`define BIT_PWR_PRI 1
`define BIT_DIFF_MODE 0
`define BIT_STAT_DIS 4
`define BIT_CMP_EN 3
`define BIT_HOLD_EN_HI 2
`define BIT_HOLD_MANUAL 1
`define BIT_HOLD_EN_LO 0
`define PIN_LEVEL_LOCK 6'h00
`define PIN_PCH_OD 6'h01
`define PIN_NCH_OD 6'h02
`define PIN_HIZ 6'h03
`define PIN_CURRENT 6'h04
`endif

// ===== design/pll_ref_lock_holdover_ctrl.v
// pll supervision register bank: buffered/active registers, pin selectors, reference switchover
// assumes a serial port engine on clk delivering decoded byte reads/writes; analog status arrives async
`timescale 1ns/100ps
`include "pll_supervisor_consts.vh"

module pll_ref_lock_holdover_ctrl (
	input wire clk,
	input wire reset,
	input wire wr_stb,
	input wire rd_stb,
	input wire [9:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata,
	output reg rvalid,
	input wire align_pin,
	input wire ref_sel_pin,
	input wire ref_clk_en,
	input wire primary_reference,
	input wire secondary_reference,
	input wire pri_freq_high,
	input wire pri_freq_low,
	input wire sec_freq_high,
	input wire sec_freq_low,
	input wire vco_freq_ok_raw,
	input wire lock_raw,
	input wire cal_done_raw,
	input wire lock_cmp_raw,
	output reg lock_detect_run,
	output reg cal_clk_en,
	output reg cal_start,
	output reg counters_rst_async,
	output reg counters_rst_sync,
	output reg [2:0] monitor_run,
	output reg sel_secondary,
	output reg pwr_primary,
	output reg pwr_secondary,
	output reg diff_mode,
	output reg holdover_active,
	output reg lock_indicator_pin_o,
	output reg lock_indicator_pin_oe_n,
	output reg lock_current_on,
	output reg reference_watch_pin
);

// buffered copies take host writes; only the active copies steer the logic
reg [7:0] buf_lock_cal_reg;
reg [7:0] buf_align_reg;
reg [7:0] buf_pin_reg;
reg [7:0] buf_mon_reg;
reg [7:0] buf_sel_reg;
reg [7:0] buf_hold_reg;
reg [7:0] act_lock_cal_reg;
reg [7:0] act_align_reg;
reg [7:0] act_pin_reg;
reg [7:0] act_mon_reg;
reg [7:0] act_sel_reg;
reg [7:0] act_hold_reg;
reg readback_active_reg;
reg cal_prev_reg;
reg [3:0] cal_div_reg;
reg auto_on_secondary_reg;
reg lock_seen_reg;
// two-stage synchronisers: stage one read only by stage two
reg [10:0] sync1_reg;
reg [10:0] sync2_reg;
reg align_prev_reg;
// bit 0 is a spare stage so the pin bits keep their places
wire [10:0] raw_in = {
	cal_done_raw,
	lock_cmp_raw,
	vco_freq_ok_raw,
	lock_raw,
	sec_freq_low,
	sec_freq_high,
	pri_freq_low,
	pri_freq_high,
	ref_sel_pin,
	align_pin,
	1'b0
};
wire s_cal_done = sync2_reg[10];
wire s_cmp = sync2_reg[9];
wire s_vco_raw = sync2_reg[8];
wire s_lock_raw = sync2_reg[7];
wire s_sec_low = sync2_reg[6];
wire s_sec_high = sync2_reg[5];
wire s_pri_low = sync2_reg[4];
wire s_pri_high = sync2_reg[3];
wire s_ref_pin = sync2_reg[2];
wire s_align = sync2_reg[1];

// monitors gated by their enables; threshold pick
wire thr_low = act_pin_reg[`BIT_REF_THRESH];
wire pri_ok = act_mon_reg[`BIT_MON_PRI] & (thr_low ? s_pri_low : s_pri_high);
wire sec_ok = act_mon_reg[`BIT_MON_SEC] & (thr_low ? s_sec_low : s_sec_high);
wire vco_ok = act_mon_reg[`BIT_MON_VCO] & s_vco_raw;
wire lock_flag = ~act_lock_cal_reg[`BIT_LOCK_DIS] & s_lock_raw;
wire auto_sw = act_sel_reg[`BIT_AUTO_SW] & ~act_sel_reg[`BIT_DIFF_MODE];
wire manual_sel = act_sel_reg[`BIT_USE_PIN] ? s_ref_pin : act_sel_reg[`BIT_SEL_SEC];
wire sel_sec_now = act_sel_reg[`BIT_DIFF_MODE] ? 1'b0 : (auto_sw ? auto_on_secondary_reg : manual_sel);
wire hold_en = act_hold_reg[`BIT_HOLD_EN_HI] & act_hold_reg[`BIT_HOLD_EN_LO];
wire hold_manual = act_hold_reg[`BIT_HOLD_MANUAL];
wire [4:0] cal_div_span = 5'h02 << act_lock_cal_reg[2:1]; // five bits so divide-by-16 fits
// previous lock taken from pin comparator when enabled in auto mode
wire prior_lock = act_hold_reg[`BIT_CMP_EN] ? s_cmp : lock_seen_reg;
wire sel_status = sel_sec_now ? sec_ok : pri_ok;
wire unsel_status = sel_sec_now ? pri_ok : sec_ok;
wire sel_clk = sel_sec_now ? secondary_reference : primary_reference;
wire unsel_clk = sel_sec_now ? primary_reference : secondary_reference;
wire [7:0] status_byte = {
	1'b0,
	s_cal_done,
	holdover_active,
	sel_sec_now,
	vco_ok,
	sec_ok,
	pri_ok,
	lock_flag
};

// shared monitor selection, codes 0..15 of the five-bit select; bit 4 inverts
function mon_sig;
	input [3:0] code;
	input cmp_allowed;
	begin
		case (code)
			4'h0: mon_sig = 1'b0;
			4'h1: mon_sig = primary_reference;
			4'h2: mon_sig = act_sel_reg[`BIT_DIFF_MODE] ? 1'b0 : secondary_reference;
			4'h3: mon_sig = sel_clk;
			4'h4: mon_sig = unsel_clk;
			4'h5: mon_sig = sel_status;
			4'h6: mon_sig = unsel_status;
			4'h7: mon_sig = pri_ok;
			4'h8: mon_sig = sec_ok;
			4'h9: mon_sig = pri_ok & sec_ok;
			4'ha: mon_sig = lock_flag & sel_status & vco_ok;
			4'hb: mon_sig = vco_ok;
			4'hc: mon_sig = sel_sec_now;
			4'hd: mon_sig = lock_flag;
			4'he: mon_sig = holdover_active;
			4'hf: mon_sig = cmp_allowed & s_cmp;
			default: mon_sig = 1'b0;
		endcase
	end
endfunction

// code 0_0000 is ground, 1_0000 gives supply; the general inversion covers both
function mon_out;
	input [4:0] code;
	input cmp_allowed;
	begin
		mon_out = code[4] ^ mon_sig(code[3:0], cmp_allowed);
	end
endfunction

function [7:0] read_mux;
	input [9:0] a;
	input act;
	begin
		case (a)
			`ADDR_LOCK_CAL: read_mux = act ? act_lock_cal_reg : buf_lock_cal_reg;
			`ADDR_ALIGN_RST: read_mux = act ? act_align_reg : buf_align_reg;
			`ADDR_LOCK_PIN: read_mux = act ? act_pin_reg : buf_pin_reg;
			`ADDR_MON_EN: read_mux = act ? act_mon_reg : buf_mon_reg;
			`ADDR_REF_SEL: read_mux = act ? act_sel_reg : buf_sel_reg;
			`ADDR_HOLDOVER: read_mux = act ? act_hold_reg : buf_hold_reg;
			`ADDR_READBACK_SEL: read_mux = {7'h00, readback_active_reg};
			default: read_mux = 8'h00;
		endcase
	end
endfunction

// register port, buffered/active pair
always @(posedge clk) begin
	if (reset) begin
		buf_lock_cal_reg <= `RST_LOCK_CAL;
		buf_align_reg <= `RST_ALIGN_RST;
		buf_pin_reg <= `RST_LOCK_PIN;
		buf_mon_reg <= `RST_MON_EN;
		buf_sel_reg <= `RST_REF_SEL;
		buf_hold_reg <= `RST_HOLDOVER;
		act_lock_cal_reg <= `RST_LOCK_CAL;
		act_align_reg <= `RST_ALIGN_RST;
		act_pin_reg <= `RST_LOCK_PIN;
		act_mon_reg <= `RST_MON_EN;
		act_sel_reg <= `RST_REF_SEL;
		act_hold_reg <= `RST_HOLDOVER;
		readback_active_reg <= 1'b0;
		rdata <= 8'h00;
		rvalid <= 1'b0;
	end else begin
		rvalid <= rd_stb;
		if (wr_stb) begin
			case (addr) // status address falls to default, write dropped
				`ADDR_LOCK_CAL: buf_lock_cal_reg <= wdata;
				`ADDR_ALIGN_RST: buf_align_reg <= wdata;
				`ADDR_LOCK_PIN: buf_pin_reg <= wdata;
				`ADDR_MON_EN: buf_mon_reg <= wdata;
				`ADDR_REF_SEL: buf_sel_reg <= wdata;
				`ADDR_HOLDOVER: buf_hold_reg <= wdata;
				`ADDR_READBACK_SEL: readback_active_reg <= wdata[0];
				`ADDR_UPDATE: begin
					if (wdata[0]) begin
						act_lock_cal_reg <= buf_lock_cal_reg;
						act_align_reg <= buf_align_reg;
						act_pin_reg <= buf_pin_reg;
						act_mon_reg <= buf_mon_reg;
						act_sel_reg <= buf_sel_reg;
						act_hold_reg <= buf_hold_reg;
					end
				end
				default: ;
			endcase
		end
		if (rd_stb) begin
			if (addr == `ADDR_STATUS)
				rdata <= act_hold_reg[`BIT_STAT_DIS] ? 8'h00 : status_byte;
			else
				rdata <= read_mux(addr, readback_active_reg);
		end
	end
end

// synchronisers and supervision state
always @(posedge clk) begin
	if (reset) begin
		sync1_reg <= 11'h000;
		sync2_reg <= 11'h000;
		align_prev_reg <= 1'b0;
		cal_prev_reg <= 1'b0;
		cal_start <= 1'b0;
		cal_div_reg <= 4'h0;
		cal_clk_en <= 1'b0;
		auto_on_secondary_reg <= 1'b0;
		lock_seen_reg <= 1'b0;
		holdover_active <= 1'b0;
		counters_rst_async <= 1'b0;
		counters_rst_sync <= 1'b0;
		lock_detect_run <= 1'b0;
		monitor_run <= 3'h0;
		sel_secondary <= 1'b0;
		pwr_primary <= 1'b0;
		pwr_secondary <= 1'b0;
		diff_mode <= 1'b0;
		lock_indicator_pin_o <= 1'b0;
		lock_indicator_pin_oe_n <= 1'b0;
		lock_current_on <= 1'b0;
		reference_watch_pin <= 1'b0;
	end else begin
		sync1_reg <= raw_in;
		sync2_reg <= sync1_reg;
		align_prev_reg <= s_align;
		lock_detect_run <= ~act_lock_cal_reg[`BIT_LOCK_DIS];
		// only a rising active bit starts calibration
		cal_prev_reg <= act_lock_cal_reg[`BIT_CAL_NOW];
		cal_start <= act_lock_cal_reg[`BIT_CAL_NOW] & ~cal_prev_reg;
		// divide reference enables by 2 << code
		cal_clk_en <= 1'b0;
		if (ref_clk_en) begin
			if ({1'b0, cal_div_reg} >= cal_div_span - 5'h01) begin
				cal_div_reg <= 4'h0;
				cal_clk_en <= 1'b1;
			end else begin
				cal_div_reg <= cal_div_reg + 4'h1;
			end
		end
		// align pin counter reset modes; sync form is one pulse on the edge
		counters_rst_async <= (act_align_reg[7:6] == 2'b01) & s_align;
		counters_rst_sync <= (act_align_reg[7:6] == 2'b10) & s_align & ~align_prev_reg;
		monitor_run <= {act_mon_reg[`BIT_MON_VCO], act_mon_reg[`BIT_MON_SEC], act_mon_reg[`BIT_MON_PRI]};
		if (!auto_sw)
			auto_on_secondary_reg <= 1'b0;
		else if (!auto_on_secondary_reg && !pri_ok && sec_ok)
			auto_on_secondary_reg <= 1'b1;
		else if (auto_on_secondary_reg && pri_ok && !act_sel_reg[`BIT_STAY_SEC])
			auto_on_secondary_reg <= 1'b0;
		sel_secondary <= sel_sec_now;
		diff_mode <= act_sel_reg[`BIT_DIFF_MODE];
		// manual power bits; automatic mode keeps both inputs powered
		pwr_secondary <= auto_sw | act_sel_reg[`BIT_PWR_SEC];
		pwr_primary <= auto_sw | act_sel_reg[`BIT_PWR_PRI];
		// holdover; prior-lock source in automatic mode
		if (lock_flag)
			lock_seen_reg <= 1'b1;
		else if (!hold_en)
			lock_seen_reg <= 1'b0;
		if (!hold_en)
			holdover_active <= 1'b0;
		else if (hold_manual)
			holdover_active <= s_align;
		else
			holdover_active <= prior_lock & ~sel_status;
		// lock pin selector; oe_n low means driven
		lock_current_on <= 1'b0;
		lock_indicator_pin_oe_n <= 1'b0;
		lock_indicator_pin_o <= 1'b0;
		if (act_pin_reg[5]) begin
			lock_indicator_pin_o <= mon_out(act_pin_reg[4:0], 1'b0);
		end else begin
			case (act_pin_reg[5:0])
				`PIN_LEVEL_LOCK: lock_indicator_pin_o <= lock_flag;
				`PIN_PCH_OD: begin
					lock_indicator_pin_o <= 1'b1;
					lock_indicator_pin_oe_n <= ~lock_flag;
				end
				`PIN_NCH_OD: lock_indicator_pin_oe_n <= lock_flag;
				`PIN_HIZ: lock_indicator_pin_oe_n <= 1'b1;
				`PIN_CURRENT: begin
					lock_indicator_pin_oe_n <= 1'b1;
					lock_current_on <= lock_flag;
				end
				default: lock_indicator_pin_o <= 1'b0;
			endcase
		end
		reference_watch_pin <= mon_out(act_mon_reg[4:0], act_hold_reg[`BIT_CMP_EN]);
	end
end

endmodule

// ===== tb/pll_ref_lock_holdover_ctrl_asserts.sv
// port-level assertions for the pll supervision register bank
// bound into the design top; sees its ports only
`timescale 1ns/100ps
module pll_sup_check (
	input wire clk,
	input wire reset,
	input wire wr_stb,
	input wire rd_stb,
	input wire [9:0] addr,
	input wire [7:0] wdata,
	input wire [7:0] rdata,
	input wire rvalid,
	input wire cal_clk_en,
	input wire cal_start,
	input wire counters_rst_async,
	input wire counters_rst_sync,
	input wire [2:0] monitor_run,
	input wire sel_secondary,
	input wire holdover_active,
	input wire lock_detect_run
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_update;
		wr_stb && addr == 10'h232 && wdata[0];
	endsequence
	sequence s_hole_read;
		rd_stb && addr == 10'h01e;
	endsequence
	a_read_answered: assert property (rd_stb |=> rvalid) else $error("read not answered");
	a_answer_cause: assert property (rvalid |-> $past(rd_stb)) else $error("stray rvalid");
	a_hole_zero: assert property (s_hole_read |=> rdata == 8'h00) else $error("unmapped read not zero");
	a_cal_cause: assert property (cal_start |-> $past(wr_stb && addr == 10'h232 && wdata[0], 2))
		else $error("cal start without update");
	a_cal_single: assert property (s_update ##2 cal_start |=> !cal_start) else $error("cal start too long");
	a_sync_pulse: assert property (counters_rst_sync |=> !counters_rst_sync) else $error("sync reset too long");
	a_reset_kind: assert property (!(counters_rst_async && counters_rst_sync)) else $error("both resets");
	a_div_pulse: assert property (cal_clk_en |=> !cal_clk_en) else $error("cal clock enable too long");
	a_lock_default: assert property ($fell(reset) |=> lock_detect_run) else $error("lock detect off");
	a_quiet_start: assert property ($fell(reset) |-> monitor_run == 3'b000 && !sel_secondary && !holdover_active)
		else $error("outputs active after reset");
endmodule
bind pll_ref_lock_holdover_ctrl pll_sup_check chk (.clk, .reset, .wr_stb, .rd_stb, .addr, .wdata, .rdata,
	.rvalid, .cal_clk_en, .cal_start, .counters_rst_async, .counters_rst_sync, .monitor_run, .sel_secondary,
	.holdover_active, .lock_detect_run);

// ===== tb/host_port_model.sv
// host side of the register port: byte writes, reads, update commands
// strobes are one-cycle pulses launched by non-blocking assignment at rising clk
`timescale 1ns/100ps
module host_port_model (
	input wire clk,
	output logic wr_stb,
	output logic rd_stb,
	output logic [9:0] addr,
	output logic [7:0] wdata
);
	initial begin
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		addr = 10'h000;
		wdata = 8'h00;
	end
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
		wdata <= ~d; // released data must not look valid
	endtask
	task automatic rd(input logic [9:0] a);
		@(posedge clk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask
	task automatic put(input logic [9:0] a, input logic [7:0] d);
		wr(a, d);
		wr(10'h232, 8'h01);
	endtask
	// calibrate bit shown low then high in the active copy
	task automatic calibrate(input logic [7:0] base);
		put(10'h018, base & 8'hfe);
		put(10'h018, base | 8'h01);
	endtask
endmodule

// ===== tb/test_pll_ref_lock_holdover_ctrl.sv
// self-checking bench for the pll supervision register bank
// host model drives the register port; status levels and pins are driven here
`timescale 1ns/100ps
module test_pll_ref_lock_holdover_ctrl;
	logic clk, reset, align_pin, ref_sel_pin, ref_clk_en, primary_reference, secondary_reference;
	logic pri_freq_high, pri_freq_low, sec_freq_high, sec_freq_low, vco_freq_ok_raw, lock_raw, cal_done_raw;
	logic lock_cmp_raw;
	wire wr_stb, rd_stb, rvalid, lock_detect_run, cal_clk_en, cal_start, counters_rst_async, counters_rst_sync;
	wire sel_secondary, pwr_primary, pwr_secondary, diff_mode, holdover_active, lock_indicator_pin_o;
	wire lock_indicator_pin_oe_n, lock_current_on, reference_watch_pin;
	wire [9:0] addr;
	wire [7:0] wdata, rdata;
	wire [2:0] monitor_run;
	logic [7:0] exp_q[$];
	// bit7 pin level, bit6 released, bits5:0 code; 101111 and 111111 left out
	logic [7:0] tab[14] = '{8'h80, 8'h81, 8'h42, 8'h43, 8'h05, 8'h20, 8'had, 8'h3d, 8'ha9, 8'h39, 8'haa, 8'hb0,
		8'h2c, 8'hbc};
	int n_mismatch = 0, num_checks = 0, seed = 37663, ph = 0, n_cal = 0, cnt, i, k;
	pll_ref_lock_holdover_ctrl dut (.clk, .reset, .wr_stb, .rd_stb, .addr, .wdata, .rdata, .rvalid, .align_pin,
		.ref_sel_pin, .ref_clk_en, .primary_reference, .secondary_reference, .pri_freq_high, .pri_freq_low,
		.sec_freq_high, .sec_freq_low, .vco_freq_ok_raw, .lock_raw, .cal_done_raw, .lock_cmp_raw,
		.lock_detect_run, .cal_clk_en, .cal_start, .counters_rst_async, .counters_rst_sync, .monitor_run,
		.sel_secondary, .pwr_primary, .pwr_secondary, .diff_mode, .holdover_active, .lock_indicator_pin_o,
		.lock_indicator_pin_oe_n, .lock_current_on, .reference_watch_pin);
	host_port_model host (.clk, .wr_stb, .rd_stb, .addr, .wdata);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		host.rd(a);
	endtask
	task automatic settle;
		repeat (8) @(posedge clk);
		#1;
	endtask
	// reference clock enable every third cycle keeps divider periods exact
	always @(posedge clk) begin
		ph <= (ph == 2) ? 0 : ph + 1;
		ref_clk_en <= (ph == 2);
		primary_reference <= 1'($random(seed));
		secondary_reference <= 1'($random(seed));
		if (cal_start === 1'b1)
			n_cal <= n_cal + 1;
		if (rvalid === 1'b1)
			check("rdata", exp_q.size() ? exp_q.pop_front() : 8'hxx, rdata);
	end
	initial begin
		#400000;
		n_mismatch++;
		$display("[FAIL] run expected finish seen timeout");
		report_and_stop;
	end
	initial begin
		{reset, align_pin, ref_sel_pin} = 3'b100;
		{pri_freq_high, pri_freq_low, sec_freq_high, sec_freq_low, vco_freq_ok_raw} = 5'b0;
		{lock_raw, cal_done_raw, lock_cmp_raw} = 3'b0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		settle;
		check("lock run", 1, lock_detect_run);
		rd(10'h018, 8'h06);
		for (i = 0; i < 6; i++) rd(10'(10'h019 + i), 8'h00);
		{pri_freq_high, sec_freq_high, vco_freq_ok_raw, lock_raw, cal_done_raw} <= 5'h1f;
		host.put(10'h01b, 8'he0);
		host.put(10'h004, 8'h01);
		settle;
		check("monitors", 3'b111, monitor_run);
		rd(10'h01f, 8'h4f);
		host.wr(10'h01b, 8'h00);
		rd(10'h01b, 8'he0);
		host.put(10'h004, 8'h00);
		rd(10'h01b, 8'h00);
		host.put(10'h01b, 8'he0);
		{pri_freq_high, pri_freq_low, sec_freq_low} <= 3'b011;
		host.put(10'h01a, 8'h40);
		settle;
		rd(10'h01f, 8'h4f);
		host.put(10'h01a, 8'h00);
		host.put(10'h018, 8'h0e);
		host.put(10'h01f, 8'hff);
		settle;
		check("lock run", 0, lock_detect_run);
		rd(10'h01f, 8'h4c);
		host.put(10'h01d, 8'h10);
		rd(10'h01f, 8'h00);
		host.put(10'h01d, 8'h00);
		host.put(10'h018, 8'h06);
		pri_freq_high <= 1'b1;
		foreach (tab[j]) begin
			host.put(10'h01a, {2'b00, tab[j][5:0]});
			settle;
			check("oe_n", {7'd0, tab[j][6]}, lock_indicator_pin_oe_n);
			if (!tab[j][6]) check("pin", {7'd0, tab[j][7]}, lock_indicator_pin_o);
		end
		host.put(10'h01a, 8'h04);
		settle;
		check("current", 1, lock_current_on);
		host.put(10'h01c, 8'h46);
		settle;
		check("sel", 1, sel_secondary);
		check("pwr", 2'b11, {pwr_secondary, pwr_primary});
		rd(10'h01f, 8'h5f);
		host.put(10'h01c, 8'h62);
		settle;
		check("sel", 0, sel_secondary);
		check("pwr", 2'b01, {pwr_secondary, pwr_primary});
		ref_sel_pin <= 1'b1;
		settle;
		check("sel", 1, sel_secondary);
		host.put(10'h01c, 8'h01);
		settle;
		check("diff", 2'b10, {diff_mode, sel_secondary});
		for (i = 0; i < 2; i++) begin
			host.put(10'h01c, i ? 8'h18 : 8'h10);
			pri_freq_high <= 1'b0;
			settle;
			check("auto sel", 1, sel_secondary);
			pri_freq_high <= 1'b1;
			settle;
			check("auto back", 8'(i), sel_secondary);
		end
		host.put(10'h01c, 8'h00);
		for (i = 0; i < 4; i++) begin
			host.put(10'h019, 8'(i << 6));
			align_pin <= 1'b1;
			cnt = 0;
			repeat (8) begin
				@(posedge clk);
				#1 cnt += counters_rst_sync;
				if (counters_rst_async === 1'b1) cnt |= 16;
			end
			check("align", 8'(i == 1 ? 16 : i == 2), 8'(cnt));
			align_pin <= 1'b0;
			settle;
		end
		for (i = 0; i < 2; i++) begin
			host.put(10'h01d, i ? 8'h07 : 8'h06);
			align_pin <= 1'b1;
			settle;
			check("holdover", 8'(i), holdover_active);
			align_pin <= 1'b0;
			settle;
		end
		host.put(10'h01d, 8'h05);
		pri_freq_high <= 1'b0;
		settle;
		check("auto hold", 1, holdover_active);
		host.put(10'h01d, 8'h0d);
		settle;
		check("cmp hold", 0, holdover_active);
		lock_cmp_raw <= 1'b1;
		host.put(10'h01b, 8'hef);
		settle;
		check("cmp hold", 1, holdover_active);
		check("watch", 1, reference_watch_pin);
		host.put(10'h01b, 8'he0);
		host.put(10'h01d, 8'h00);
		pri_freq_high <= 1'b1;
		for (i = 0; i < 4; i++) begin
			host.put(10'h018, 8'(i << 1));
			settle;
			for (k = 0; k < 200 && cal_clk_en !== 1'b1; k++) begin
				@(posedge clk);
				#1;
			end
			check("cal en", 1, cal_clk_en);
			cnt = 0;
			repeat (30 << i) begin
				@(posedge clk);
				#1 cnt += cal_clk_en;
			end
			check("cal div", 5, 8'(cnt));
		end
		host.calibrate(8'h06);
		host.put(10'h018, 8'h07);
		settle;
		check("cal", 1, 8'(n_cal));
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		settle;
		check("lock run", 1, lock_detect_run);
		rd(10'h018, 8'h06);
		settle;
		check("pending", 0, 8'(exp_q.size()));
		report_and_stop;
	end
endmodule
